//--- verilog/serial_xcvr_regs.vh
`ifndef SERIAL_XCVR_REGS_VH
`define SERIAL_XCVR_REGS_VH
`define FMT_8_NONE 2'h0
`define FMT_8_EVEN 2'h1
`define FMT_8_ODD 2'h2
`define FMT_9_NONE 2'h3
`define FMT_RESET 2'h0
`define STOP_RESET 1'h0
`define FIFO_DEPTH 4
`define OVERSAMPLE 16
`define OVS_LAST 4'hF
`define OVS_MID 4'h7
`define MODE_ENABLE_BIT 15
`define MODE_ALT_BIT 10
`define STAT_TXISEL_BIT 15
`define STAT_BREAK_BIT 11
`define STAT_TXFULL_BIT 9
`define STAT_DA_BIT 0
`define RXISEL_THREE 2'h2
`define RXISEL_FOUR 2'h3
`endif

//--- verilog/char_fifo.v
`timescale 1ns/1ps
`include "serial_xcvr_regs.vh"
module char_fifo #(
	parameter WIDTH = 11,
	parameter DEPTH = `FIFO_DEPTH
) (
	clock,
	rst,
	ce,
	flush,
	push,
	push_data,
	pop,
	head_data,
	count
);
	input wire clock;
	input wire rst;
	input wire ce;
	input wire flush;
	input wire push;
	input wire [WIDTH-1:0] push_data;
	input wire pop;
	output wire [WIDTH-1:0] head_data;
	output wire [2:0] count;
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [1:0] rd_ff;
	reg [1:0] wr_ff;
	reg [2:0] cnt_ff;
	wire do_push;
	wire do_pop;
	// a full push is dropped so contents and order stay intact
	assign do_push = push && (cnt_ff != DEPTH);
	// an empty pop leaves the stale head in place
	assign do_pop = pop && (cnt_ff != 3'h0);
	assign head_data = mem_ff[rd_ff];
	assign count = cnt_ff;
	always @(posedge clock) begin
		if (rst || (ce && flush)) begin
			rd_ff <= 2'h0;
			wr_ff <= 2'h0;
			cnt_ff <= 3'h0;
		end else if (ce) begin
			if (do_push) begin
				mem_ff[wr_ff] <= push_data;
				wr_ff <= wr_ff + 2'h1;
			end
			if (do_pop)
				rd_ff <= rd_ff + 2'h1;
			if (do_push && !do_pop)
				cnt_ff <= cnt_ff + 3'h1;
			else if (do_pop && !do_push)
				cnt_ff <= cnt_ff - 3'h1;
		end
	end
endmodule // char_fifo

//--- verilog/async_serial_transceiver.v
`timescale 1ns/1ps
`include "serial_xcvr_regs.vh"
// Notes on behaviour
// (R1) enabled: drive transmit pin as output, receive pin as input; line idles high
// (R2) disabled after reset; pins to port control, buffers empty, baud counter cleared
// (R3) disable clears data, error, enable, break, full flags; sets idle and shifter-empty
// (R4) disabling aborts transfers; re-enabling resumes with the held configuration
// (R5) alternate select one uses alternate pin pair, zero the primary pair
// (R6) format field: 8 even, 8 odd, 8 none, or 9 data bits
// (R7) stop-count select appends one or two stop bits
// (R8) power-on framing is eight data bits, no parity, one stop bit
// (R9) written character loads shifter at once; enable starts from cleared baud clock
// (R10) software writes nine-bit words with upper seven bits zero
// (R11) transmit buffer holds four characters, full flag reports full
// (R12) write to full transmit buffer is discarded
// (R13) both buffers emptied by any reset
// (R14) transmit irq edge on each load, or only when load empties buffer; code fires on a load at count one, even with a write that cycle
// (R15) break-send forces transmit line low over everything
// (R16) software holds break at least 13 baud clocks then waits for stops
// (R17) break does not raise transmit irq
// (R18) reading receive data advances buffer; error flags follow new head
// (R19) receive buffer four deep; data-available when nonempty; empty read is stale
// (R20) receive irq per transfer, or at three words, or at four words
// (R21) overrun set on stop with full buffer; receive stops until cleared
// (R22) framing error when a stop bit samples zero; stored per word
// (R23) parity error on mismatch with selected parity; stored per word
// (R24) bit rate is clock over sixteen times divisor plus one
// (R25) receiver idle low from start detect until stop completes
// (R26) frame: low start, data lsb first, optional parity, high stop bits
// (R27) receiver detects falling edge, samples bit centres at sixteen-times clock
module async_serial_transceiver (
	clock,
	rst,
	ce,
	module_enable,
	alt_pin_select,
	format_select,
	stop_count_select,
	baud_divisor,
	transmit_enable,
	send_break,
	tx_irq_select,
	rx_irq_select,
	tx_write,
	transmit_data_register,
	rx_read,
	overrun_clear,
	serial_in_pin,
	alt_serial_in_pin,
	serial_out_pin,
	serial_out_oe,
	alt_serial_out_pin,
	alt_serial_out_oe,
	receive_data_register,
	rx_data_available,
	parity_flag,
	framing_flag,
	overrun_flag,
	receiver_idle,
	shifter_empty,
	tx_buffer_full,
	transmit_enabled,
	break_active,
	tx_irq_flag,
	rx_irq_flag
);
	input wire clock;
	input wire rst;
	input wire ce;
	input wire module_enable;
	input wire alt_pin_select;
	input wire [1:0] format_select;
	input wire stop_count_select;
	input wire [15:0] baud_divisor;
	input wire transmit_enable;
	input wire send_break;
	input wire tx_irq_select;
	input wire [1:0] rx_irq_select;
	input wire tx_write;
	input wire [8:0] transmit_data_register;
	input wire rx_read;
	input wire overrun_clear;
	input wire serial_in_pin;
	input wire alt_serial_in_pin;
	output reg serial_out_pin;
	output reg serial_out_oe;
	output reg alt_serial_out_pin;
	output reg alt_serial_out_oe;
	output reg [8:0] receive_data_register;
	output reg rx_data_available;
	output reg parity_flag;
	output reg framing_flag;
	output reg overrun_flag;
	output reg receiver_idle;
	output reg shifter_empty;
	output reg tx_buffer_full;
	output reg transmit_enabled;
	output reg break_active;
	output reg tx_irq_flag;
	output reg rx_irq_flag;

	localparam TX_IDLE = 4'b0001;
	localparam TX_START = 4'b0010;
	localparam TX_BITS = 4'b0100;
	localparam TX_STOP = 4'b1000;
	localparam RX_IDLE = 4'b0001;
	localparam RX_START = 4'b0010;
	localparam RX_BITS = 4'b0100;
	localparam RX_STOP = 4'b1000;

	// number of data plus parity bits for a format
	function [3:0] frame_bits;
		input [1:0] fmt;
		begin
			frame_bits = (fmt == `FMT_8_NONE) ? 4'h8 : 4'h9;
		end
	endfunction

	// expected parity bit for a nine-bit shifted word
	function par_bit;
		input [1:0] fmt;
		input [7:0] d;
		begin
			par_bit = (fmt == `FMT_8_ODD) ? ~(^d) : (^d);
		end
	endfunction

	wire on = module_enable;
	reg [15:0] baud_cnt_ff;
	reg [3:0] tick16_ff;
	wire os_tick = (baud_cnt_ff == baud_divisor);
	reg rx_s1_ff, rx_s2_ff, arx_s1_ff, arx_s2_ff;
	wire rx_line = alt_pin_select ? arx_s2_ff : rx_s2_ff; // [R5]

	// oversample tick: clock/(divisor+1), sixteen per bit
	always @(posedge clock) begin
		if (rst || (ce && (!on || (!transmit_enabled && transmit_enable)))) begin
			baud_cnt_ff <= 16'h0000; // [R2] [R9]
		end else if (ce) begin
			baud_cnt_ff <= os_tick ? 16'h0000 : baud_cnt_ff + 16'h0001; // [R24]
		end
	end

	// two-stage synchronisers on both receive pins
	always @(posedge clock) begin
		if (rst) begin
			rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;
			arx_s1_ff <= 1'b1;
			arx_s2_ff <= 1'b1;
		end else if (ce) begin
			rx_s1_ff <= serial_in_pin;
			rx_s2_ff <= rx_s1_ff;
			arx_s1_ff <= alt_serial_in_pin;
			arx_s2_ff <= arx_s1_ff;
		end
	end

	// transmit side
	wire [10:0] txf_head;
	wire [2:0] txf_count;
	reg [3:0] tx_state_ff;
	reg [8:0] tx_shift_ff;
	reg [3:0] tx_bit_ff;
	reg [3:0] tx_os_ff;
	reg tx_stop2_ff;
	reg tx_line_ff;
	wire tx_load = transmit_enabled && (tx_state_ff == TX_IDLE) && (txf_count != 3'h0) && !send_break;
	wire [8:0] tx_word = (format_select == `FMT_9_NONE) ? txf_head[8:0] :
		(format_select == `FMT_8_NONE) ? {1'b0, txf_head[7:0]} :
		{par_bit(format_select, txf_head[7:0]), txf_head[7:0]};

	char_fifo #(.WIDTH(11), .DEPTH(`FIFO_DEPTH)) tx_fifo (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.flush(!on), // [R2] [R13]
		.push(tx_write && on), // [R12]
		.push_data({2'b00, transmit_data_register}), // [R10]
		.pop(tx_load),
		.head_data(txf_head),
		.count(txf_count)
	);

	always @(posedge clock) begin
		if (rst || (ce && !on)) begin
			tx_state_ff <= TX_IDLE; // [R4]
			tx_shift_ff <= 9'h000;
			tx_bit_ff <= 4'h0;
			tx_os_ff <= 4'h0;
			tx_stop2_ff <= 1'b0;
			tx_line_ff <= 1'b1;
			tx_irq_flag <= 1'b0;
		end else if (ce) begin
			// one-cycle pulse marks the transfer edge
			tx_irq_flag <= tx_load && (!tx_irq_select || txf_count == 3'h1); // [R14] [R17]
			case (tx_state_ff)
				TX_IDLE: begin
					tx_line_ff <= 1'b1; // [R1]
					if (tx_load) begin
						tx_shift_ff <= tx_word; // [R6] [R9]
						tx_bit_ff <= 4'h0;
						tx_os_ff <= 4'h0;
						tx_stop2_ff <= stop_count_select;
						tx_state_ff <= TX_START;
						tx_line_ff <= 1'b0; // [R26]
					end
				end
				TX_START, TX_BITS, TX_STOP: begin
					if (os_tick) begin
						tx_os_ff <= tx_os_ff + 4'h1;
						if (tx_os_ff == `OVS_LAST) begin
							if (tx_state_ff == TX_STOP) begin
								if (tx_stop2_ff) begin
									tx_stop2_ff <= 1'b0; // [R7]
								end else begin
									tx_state_ff <= TX_IDLE;
								end
							end else if (tx_state_ff == TX_BITS && tx_bit_ff == frame_bits(format_select)) begin
								tx_state_ff <= TX_STOP;
								tx_line_ff <= 1'b1; // [R26]
							end else begin
								tx_state_ff <= TX_BITS;
								tx_line_ff <= tx_shift_ff[0];
								tx_shift_ff <= {1'b0, tx_shift_ff[8:1]};
								tx_bit_ff <= tx_bit_ff + 4'h1;
							end
						end
					end
				end
				default: tx_state_ff <= TX_IDLE;
			endcase
		end
	end

	// receive side
	wire [10:0] rxf_head;
	wire [2:0] rxf_count;
	reg [3:0] rx_state_ff;
	reg [8:0] rx_shift_ff;
	reg [3:0] rx_bit_ff;
	reg [3:0] rx_os_ff;
	reg rx_stop2_ff;
	reg rx_framing_flag_ff;
	reg rx_push_ff;
	reg [10:0] rx_word_ff;
	wire [8:0] rx_data = (format_select == `FMT_9_NONE) ? rx_shift_ff :
		(format_select == `FMT_8_NONE) ? {1'b0, rx_shift_ff[8:1]} : {1'b0, rx_shift_ff[7:0]};
	wire rx_parity_flag = (format_select == `FMT_8_EVEN || format_select == `FMT_8_ODD) &&
		(rx_shift_ff[8] != par_bit(format_select, rx_shift_ff[7:0]));
	wire rx_pop = rx_read && on; // [R18]
	wire rxf_full = (rxf_count == `FIFO_DEPTH);
	wire [2:0] rxf_after = rxf_count + 3'h1 - {2'b00, rx_pop && rxf_count != 3'h0};

	char_fifo #(.WIDTH(11), .DEPTH(`FIFO_DEPTH)) rx_fifo (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.flush(!on), // [R2] [R13]
		.push(rx_push_ff),
		.push_data(rx_word_ff), // [R22] [R23]
		.pop(rx_pop),
		.head_data(rxf_head),
		.count(rxf_count)
	);

	always @(posedge clock) begin
		if (rst || (ce && !on)) begin
			rx_state_ff <= RX_IDLE; // [R4]
			rx_shift_ff <= 9'h000;
			rx_bit_ff <= 4'h0;
			rx_os_ff <= 4'h0;
			rx_stop2_ff <= 1'b0;
			rx_framing_flag_ff <= 1'b0;
			rx_push_ff <= 1'b0;
			rx_word_ff <= 11'h000;
			rx_irq_flag <= 1'b0;
			overrun_flag <= 1'b0; // [R3]
		end else if (ce) begin
			rx_push_ff <= 1'b0;
			rx_irq_flag <= 1'b0;
			if (rx_push_ff) begin
				// count after the transfer decides the irq edge
				rx_irq_flag <= !rx_irq_select[1] ||
					(rx_irq_select == `RXISEL_THREE && rxf_after == 3'h3) ||
					(rx_irq_select == `RXISEL_FOUR && rxf_after == 3'h4); // [R20]
			end
			if (overrun_clear)
				overrun_flag <= 1'b0; // [R21]
			case (rx_state_ff)
				RX_IDLE: begin
					if (!rx_line && !overrun_flag) begin
						rx_state_ff <= RX_START; // [R27] [R21]
						rx_os_ff <= 4'h0;
						rx_bit_ff <= 4'h0;
						rx_framing_flag_ff <= 1'b0;
						rx_stop2_ff <= stop_count_select;
					end
				end
				RX_START, RX_BITS, RX_STOP: begin
					if (os_tick) begin
						rx_os_ff <= rx_os_ff + 4'h1;
						if (rx_os_ff == `OVS_MID) begin // [R27]
							if (rx_state_ff == RX_START) begin
								// a glitch shorter than half a bit is not a start
								if (rx_line)
									rx_state_ff <= RX_IDLE;
							end else if (rx_state_ff == RX_BITS) begin
								rx_shift_ff <= {rx_line, rx_shift_ff[8:1]}; // [R26]
							end else begin
								if (!rx_line)
									rx_framing_flag_ff <= 1'b1; // [R22]
							end
						end
						if (rx_os_ff == `OVS_LAST) begin
							if (rx_state_ff == RX_START) begin
								rx_state_ff <= RX_BITS;
							end else if (rx_state_ff == RX_BITS) begin
								rx_bit_ff <= rx_bit_ff + 4'h1;
								if (rx_bit_ff == frame_bits(format_select) - 4'h1)
									rx_state_ff <= RX_STOP;
							end else if (rx_stop2_ff) begin
								rx_stop2_ff <= 1'b0; // [R22]
							end else begin
								rx_state_ff <= RX_IDLE; // [R25]
								if (rxf_full && !rx_pop) begin
									overrun_flag <= 1'b1; // [R21]
								end else begin
									rx_push_ff <= 1'b1;
									rx_word_ff <= {rx_framing_flag_ff, rx_parity_flag, rx_data}; // [R23]
								end
							end
						end
					end
				end
				default: rx_state_ff <= RX_IDLE;
			endcase
		end
	end

	// registered outputs and pin steering
	always @(posedge clock) begin
		if (rst) begin
			serial_out_pin <= 1'b1;
			serial_out_oe <= 1'b0; // [R2]
			alt_serial_out_pin <= 1'b1;
			alt_serial_out_oe <= 1'b0;
			receive_data_register <= 9'h000;
			rx_data_available <= 1'b0;
			parity_flag <= 1'b0;
			framing_flag <= 1'b0;
			receiver_idle <= 1'b1;
			shifter_empty <= 1'b1;
			tx_buffer_full <= 1'b0;
			transmit_enabled <= 1'b0;
			break_active <= 1'b0;
		end else if (ce) begin
			serial_out_oe <= on && !alt_pin_select; // [R1] [R5]
			alt_serial_out_oe <= on && alt_pin_select;
			serial_out_pin <= !(on && break_active) && (tx_line_ff || !on); // [R15]
			alt_serial_out_pin <= !(on && break_active) && (tx_line_ff || !on);
			transmit_enabled <= on && transmit_enable; // [R3]
			break_active <= on && send_break; // [R3] [R15]
			tx_buffer_full <= on && (txf_count == `FIFO_DEPTH); // [R11]
			shifter_empty <= !on || (tx_state_ff == TX_IDLE && !tx_load); // [R3]
			receiver_idle <= !on || (rx_state_ff == RX_IDLE); // [R25]
			rx_data_available <= on && (rxf_count != 3'h0); // [R19]
			// an empty buffer keeps the last word on show instead of a wrapped slot
			if (rxf_count != 3'h0)
				receive_data_register <= rxf_head[8:0]; // [R19]
			parity_flag <= on && rxf_head[9]; // [R18]
			framing_flag <= on && rxf_head[10];
		end
	end
endmodule // async_serial_transceiver

//--- bench/serial_props.sv
`timescale 1ns/1ps
module serial_props (
	input wire clock,
	input wire rst,
	input wire module_enable,
	input wire alt_pin_select,
	input wire transmit_enable,
	input wire send_break,
	input wire serial_out_pin,
	input wire serial_out_oe,
	input wire alt_serial_out_oe,
	input wire rx_data_available,
	input wire overrun_flag,
	input wire receiver_idle,
	input wire shifter_empty,
	input wire tx_buffer_full,
	input wire transmit_enabled,
	input wire break_active,
	input wire tx_irq_flag,
	input wire rx_irq_flag
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// three cycles of margin cover the output register stage
	a_disabled_pins: assert property (!module_enable [*3] |-> !serial_out_oe && !alt_serial_out_oe)
		else $error("pins driven while disabled");
	a_alt_pins: assert property ((module_enable && alt_pin_select) [*3] |-> alt_serial_out_oe && !serial_out_oe)
		else $error("alternate pair not in use");
	a_primary_pins: assert property ((module_enable && !alt_pin_select) [*3] |-> serial_out_oe && !alt_serial_out_oe)
		else $error("primary pair not in use");
	a_break_low: assert property ((module_enable && !alt_pin_select && send_break && transmit_enable) [*3]
		|-> !serial_out_pin)
		else $error("line not low during break");
	a_break_quiet: assert property (break_active |-> !tx_irq_flag)
		else $error("transmit irq during break");
	a_tx_edge: assert property (tx_irq_flag |=> !tx_irq_flag)
		else $error("transmit irq longer than one cycle");
	a_rx_edge: assert property (rx_irq_flag |=> !rx_irq_flag)
		else $error("receive irq longer than one cycle");
	a_disable_flags: assert property (!module_enable [*3] |-> receiver_idle && shifter_empty && !rx_data_available
		&& !overrun_flag && !tx_buffer_full && !transmit_enabled && !break_active)
		else $error("flags not cleared while disabled");
	a_overrun_data: assert property ($rose(overrun_flag) |-> rx_data_available)
		else $error("overrun without held data");
	a_reset_state: assert property (disable iff (1'b0) rst |=> receiver_idle && shifter_empty
		&& !rx_data_available && !tx_buffer_full && !overrun_flag)
		else $error("wrong state after reset");
	c_tx_irq: cover property (tx_irq_flag);
	c_rx_irq: cover property (rx_irq_flag);
	c_overrun: cover property ($rose(overrun_flag));
	c_full: cover property (tx_buffer_full);
endmodule // serial_props
bind async_serial_transceiver serial_props u_props (.clock, .rst, .module_enable, .alt_pin_select,
	.transmit_enable, .send_break, .serial_out_pin, .serial_out_oe, .alt_serial_out_oe, .rx_data_available,
	.overrun_flag, .receiver_idle, .shifter_empty, .tx_buffer_full, .transmit_enabled, .break_active,
	.tx_irq_flag, .rx_irq_flag);

//--- bench/remote_end.sv
`timescale 1ns/1ps
module remote_end (
	input wire clock,
	input wire line,
	input wire go,
	input wire [3:0] len,
	input wire [11:0] word,
	output reg tx,
	output reg [11:0] got,
	output reg done
);
	integer i;
	integer j;
	initial begin
		tx = 1'b1;
		done = 1'b0;
	end
	// low start, then the word lsb first, sixteen clocks a bit
	always @(posedge go) begin
		@(posedge clock);
		tx <= 1'b0;
		for (i = 0; i <= len; i = i + 1) begin
			repeat (16) @(posedge clock);
			tx <= (i == len) ? 1'b1 : word[i];
		end
	end
	// mid-bit sampling tolerates a few clocks of skew
	always @(negedge line) begin
		got <= 12'h000;
		repeat (8) @(posedge clock);
		for (j = 0; j < len; j = j + 1) begin
			repeat (16) @(posedge clock);
			got[j] <= line;
		end
		done <= 1'b1;
		@(posedge clock);
		done <= 1'b0;
	end
endmodule // remote_end

//--- bench/async_serial_transceiver_bench.sv
`timescale 1ns/1ps
`define check(n, e, s) \
	begin \
		samples_checked = samples_checked + 1; \
		if ((s) !== (e)) begin \
			fails = fails + 1; \
			$display("wrong value %s expected %h seen %h", n, e, s); \
		end \
	end
`define wait_until(c) for (k = 0; k < 700 && !(c); k = k + 1) @(posedge clock);
module async_serial_transceiver_bench;
	reg clock = 1'b0;
	reg rst = 1'b1;
	reg ce = 1'b1;
	wire [15:0] baud_divisor = 16'h0000;
	reg module_enable = 1'b0, alt_pin_select = 1'b0, stop_count_select = 1'b0, transmit_enable = 1'b0;
	reg send_break = 1'b0, tx_irq_select = 1'b0, tx_write = 1'b0, rx_read = 1'b0, overrun_clear = 1'b0, go = 1'b0;
	reg [1:0] format_select = 2'h0, rx_irq_select = 2'h0;
	reg [8:0] transmit_data_register = 9'h000;
	reg [3:0] len = 4'h9;
	reg [11:0] word = 12'h000;
	wire serial_out_pin, serial_out_oe, alt_serial_out_pin, alt_serial_out_oe, rx_data_available, parity_flag;
	wire framing_flag, overrun_flag, receiver_idle, shifter_empty, tx_buffer_full, transmit_enabled, break_active;
	wire tx_irq_flag, rx_irq_flag, mtx, done;
	wire [8:0] receive_data_register;
	wire [11:0] got;
	// released pins read as the pull-up level
	wire line = serial_out_oe ? serial_out_pin : (alt_serial_out_oe ? alt_serial_out_pin : 1'b1);
	wire serial_in_pin = alt_pin_select ? 1'b1 : mtx;
	wire alt_serial_in_pin = alt_pin_select ? mtx : 1'b1;
	integer fails = 0, samples_checked = 0, txc = 0, rxc = 0, r, k, m;
	reg [25:0] rows [0:8];
	reg [15:0] fr;
	async_serial_transceiver DUT (.clock, .rst, .ce, .module_enable, .alt_pin_select, .format_select,
		.stop_count_select, .baud_divisor, .transmit_enable, .send_break, .tx_irq_select, .rx_irq_select,
		.tx_write, .transmit_data_register, .rx_read, .overrun_clear, .serial_in_pin, .alt_serial_in_pin,
		.serial_out_pin, .serial_out_oe, .alt_serial_out_pin, .alt_serial_out_oe, .receive_data_register,
		.rx_data_available, .parity_flag, .framing_flag, .overrun_flag, .receiver_idle, .shifter_empty,
		.tx_buffer_full, .transmit_enabled, .break_active, .tx_irq_flag, .rx_irq_flag);
	remote_end partner (.clock, .line, .go, .len, .word, .tx(mtx), .got, .done);
	always #4 clock = ~clock;
	always @(posedge clock) begin
		if (tx_irq_flag === 1'b1) txc <= txc + 1;
		if (rx_irq_flag === 1'b1) rxc <= rxc + 1;
	end
	// bits after the start bit, and how many of them
	function [15:0] frame(input [1:0] f, input s, input [8:0] d);
		reg [8:0] v;
		reg [3:0] n;
		begin
			v = (f == 2'h3) ? d : {(f == 2'h1) ? ^d[7:0] : ~^d[7:0], d[7:0]};
			n = (f == 2'h0) ? 4'h8 : 4'h9;
			frame = {n + 4'h1 + {3'h0, s}, (12'h600 >> (4'h9 - n)) | {3'h0, v}};
		end
	endfunction
	task put(input [8:0] d);
		begin
			transmit_data_register <= d;
			tx_write <= 1'b1;
			@(posedge clock);
			tx_write <= 1'b0;
		end
	endtask
	task hear(input [1:0] f, input s, input [8:0] d);
		begin
			fr = frame(f, s, d);
			`wait_until(done === 1'b1)
			`check("line bits", fr[11:0] & ~(12'hFFF << fr[15:12]), got)
			@(posedge clock);
		end
	endtask
	task send_rx(input [1:0] f, input s, input [8:0] d, input [11:0] flip);
		begin
			fr = frame(f, s, d);
			len <= fr[15:12];
			word <= fr[11:0] ^ flip;
			go <= 1'b1;
			@(posedge clock);
			go <= 1'b0;
			repeat (230) @(posedge clock);
		end
	endtask
	task take(input [8:0] e, input ep, input ef);
		begin
			`check("data ready", 1'b1, rx_data_available)
			`check("rx data", e, receive_data_register)
			`check("parity", ep, parity_flag)
			`check("framing", ef, framing_flag)
			rx_read <= 1'b1;
			@(posedge clock);
			rx_read <= 1'b0;
			repeat (3) @(posedge clock);
		end
	endtask
	task xfer(input [25:0] w);
		begin
			@(posedge clock);
			format_select <= w[25:24];
			stop_count_select <= w[23];
			fr = frame(w[25:24], w[23], w[22:14]);
			len <= fr[15:12];
			@(posedge clock);
			put(w[22:14]);
			hear(w[25:24], w[23], w[22:14]);
			send_rx(w[25:24], w[23], w[22:14], w[13:2]);
			take(w[25:24] == 2'h3 ? w[22:14] : {1'b0, w[21:14]}, w[1], w[0]);
		end
	endtask
	task conclude;
		begin
			$display("checks %0d fails %0d", samples_checked, fails);
			if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
			else $display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		repeat (30000) @(posedge clock);
		fails = fails + 1;
		conclude;
	end
	initial begin
		rows[0] = {2'h0, 1'h0, 9'h0A5, 12'h000, 2'h0};
		rows[1] = {2'h1, 1'h0, 9'h0A7, 12'h000, 2'h0};
		rows[2] = {2'h2, 1'h1, 9'h03C, 12'h000, 2'h0};
		rows[3] = {2'h3, 1'h1, 9'h1C3, 12'h000, 2'h0};
		rows[4] = {2'h3, 1'h0, 9'h155, 12'h000, 2'h0};
		rows[5] = {2'h1, 1'h1, 9'h0FF, 12'h000, 2'h0};
		rows[6] = {2'h1, 1'h0, 9'h0A7, 12'h100, 2'h2};
		rows[7] = {2'h0, 1'h0, 9'h05A, 12'h100, 2'h1};
		rows[8] = {2'h0, 1'h1, 9'h05A, 12'h200, 2'h1};
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		`check("idle after reset", 1'b1, receiver_idle & shifter_empty)
		`check("released", 1'b0, serial_out_oe | rx_data_available | tx_buffer_full)
		module_enable <= 1'b1;
		transmit_enable <= 1'b1;
		repeat (4) @(posedge clock);
		`check("primary drives", 2'h2, {serial_out_oe, alt_serial_out_oe})
		`check("idles high", 1'b1, serial_out_pin)
		for (r = 0; r < 9; r = r + 1) begin
			xfer(rows[r]);
			`check("tx irqs", r + 1, txc)
			`check("rx irqs", r + 1, rxc)
		end
		alt_pin_select <= 1'b1;
		repeat (4) @(posedge clock);
		`check("alt drives", 2'h1, {serial_out_oe, alt_serial_out_oe})
		xfer(rows[3]);
		alt_pin_select <= 1'b0;
		transmit_enable <= 1'b0;
		tx_irq_select <= 1'b1;
		format_select <= 2'h0;
		stop_count_select <= 1'b0;
		len <= 4'h9;
		m = txc;
		@(posedge clock);
		tx_write <= 1'b1;
		for (k = 1; k < 6; k = k + 1) begin
			transmit_data_register <= k[8:0];
			@(posedge clock);
		end
		tx_write <= 1'b0;
		repeat (3) @(posedge clock);
		`check("tx full", 1'b1, tx_buffer_full)
		ce <= 1'b0;
		transmit_enable <= 1'b1;
		repeat (5) @(posedge clock);
		`check("frozen", 2'h3, {tx_buffer_full, shifter_empty})
		ce <= 1'b1;
		for (r = 1; r < 5; r = r + 1) hear(2'h0, 1'b0, r[8:0]);
		`check("irq when drained", m + 1, txc)
		tx_irq_select <= 1'b0;
		rx_irq_select <= 2'h2;
		m = rxc;
		for (r = 1; r < 4; r = r + 1) send_rx(2'h0, 1'b0, r[8:0], 12'h000);
		`check("irq at three", m + 1, rxc)
		rx_irq_select <= 2'h3;
		send_rx(2'h0, 1'b0, 9'h004, 12'h000);
		`check("irq at four", m + 2, rxc)
		send_rx(2'h0, 1'b0, 9'h005, 12'h000);
		`check("overrun", 1'b1, overrun_flag)
		for (r = 1; r < 5; r = r + 1) take(r[8:0], 1'b0, 1'b0);
		`check("empty", 1'b0, rx_data_available)
		rx_read <= 1'b1;
		@(posedge clock);
		rx_read <= 1'b0;
		overrun_clear <= 1'b1;
		@(posedge clock);
		overrun_clear <= 1'b0;
		repeat (3) @(posedge clock);
		`check("stale head", 9'h004, receive_data_register)
		`check("overrun cleared", 1'b0, overrun_flag)
		m = txc;
		send_break <= 1'b1;
		repeat (208) @(posedge clock);
		`check("break low", 2'h1, {serial_out_pin, break_active})
		send_break <= 1'b0;
		repeat (40) @(posedge clock);
		`check("stop after break", 1'b1, serial_out_pin)
		`check("no break irq", m, txc)
		put(9'h0C3);
		repeat (60) @(posedge clock);
		module_enable <= 1'b0;
		repeat (4) @(posedge clock);
		`check("abort idle", 2'h3, {shifter_empty, receiver_idle})
		`check("abort flags", 3'h0, {transmit_enabled, tx_buffer_full, serial_out_oe})
		module_enable <= 1'b1;
		transmit_enable <= 1'b0;
		repeat (200) @(posedge clock);
		transmit_enable <= 1'b1;
		xfer(rows[2]);
		conclude;
	end
endmodule // async_serial_transceiver_bench
